// ==== core/awc_top.sv ====
// Purpose: Wait-state control registers for external areas 5, 4 and 3
// Assumes: APB master on pclk; access requests from logic on pclk
// Notes:   One-wait APB slave; unmapped addresses read zero, pslverr set
//
// The implementer's own choices: the register addresses and the APB slave port.

`timescale 1ns/100ps
`default_nettype none

// Operation
// - Area 5 field codes zero to seven waits
// - Area 5 waits only when its bit set
// - Area 4 field codes zero to seven waits
// - Area 4 waits only when its bit set
// - Area 3 field codes zero to seven waits
// - Area 3 waits only when its bit set
// - Reserved bits read zero, ignore writes
// - Bit clear means two-state, no waits
module awc_top
    import awc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata_ff,
    output var  logic        pready_ff,
    output var  logic        pslverr_ff,
    input  wire awc_req_t    acc_req,
    output var  logic        acc_busy_ff,
    output var  logic        acc_done_ff,
    output var  logic [3:0]  acc_states_ff
);

    logic [2:0] area5_wait_ff;
    logic [2:0] area4_wait_ff;
    logic [2:0] area3_wait_ff;
    logic [7:0] access_state_ctrl_reg_ff;
    logic [2:0] nxt_area5_wait;
    logic [2:0] nxt_area4_wait;
    logic [2:0] nxt_area3_wait;
    logic [7:0] nxt_access_state_ctrl_reg;
    logic [31:0] nxt_prdata;
    logic        nxt_pready;
    logic        nxt_pslverr;
    logic        wr_en;
    logic        rd_en;
    awc_cfg_t    cfg;
    awc_cfg_t    cfg_ff;
    logic        start_ff;
    logic        busy;
    logic        done;
    logic [3:0]  len;
    logic [31:0] last_cyc_ff;
    logic [31:0] nxt_last_cyc;
    logic        nxt_start;
    logic        nxt_acc_busy;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == AWC_OFS_WAIT_A_LOW) || (a == AWC_OFS_WAIT_B_HIGH) ||
                 (a == AWC_OFS_ACCESS_CTRL) || (a == AWC_OFS_CYCLE_CTRL) || (a == AWC_OFS_STATUS);
    endfunction : mapped

    assign wr_en = psel && penable && pwrite && !pready_ff;
    assign rd_en = psel && penable && !pwrite && !pready_ff;

    // Register writes; reserved bits have no storage
    always_comb begin
        nxt_area5_wait            = area5_wait_ff;
        nxt_area4_wait            = area4_wait_ff;
        nxt_area3_wait            = area3_wait_ff;
        nxt_access_state_ctrl_reg = access_state_ctrl_reg_ff;
        if (wr_en) begin
            unique case (paddr)
                AWC_OFS_WAIT_A_LOW: begin
                    nxt_area5_wait = pwdata[AWC_AREA5_LSB +: 3];
                    nxt_area4_wait = pwdata[AWC_AREA4_LSB +: 3];
                end
                AWC_OFS_WAIT_B_HIGH: begin
                    nxt_area3_wait = pwdata[AWC_AREA3_LSB +: 3];
                end
                AWC_OFS_ACCESS_CTRL: begin
                    nxt_access_state_ctrl_reg = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; one-cycle wait so pready comes from a flop
    always_comb begin
        nxt_prdata  = 32'h0;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        if (psel && penable && !pready_ff) begin
            nxt_pready  = 1'b1;
            nxt_pslverr = !mapped(paddr);
            if (rd_en) begin
                unique case (paddr)
                    AWC_OFS_WAIT_A_LOW:  nxt_prdata = {24'h0, 1'b0, area5_wait_ff, 1'b0, area4_wait_ff};
                    AWC_OFS_WAIT_B_HIGH: nxt_prdata = {16'h0, 1'b0, area3_wait_ff, 12'h0};
                    AWC_OFS_ACCESS_CTRL: nxt_prdata = {24'h0, access_state_ctrl_reg_ff};
                    AWC_OFS_STATUS:      nxt_prdata = last_cyc_ff;
                    default:             nxt_prdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            area5_wait_ff            <= AWC_WAIT_RST;
            area4_wait_ff            <= AWC_WAIT_RST;
            area3_wait_ff            <= AWC_WAIT_RST;
            access_state_ctrl_reg_ff <= AWC_AST_RST;
            prdata_ff                <= 32'h0;
            pready_ff                <= 1'b0;
            pslverr_ff               <= 1'b0;
        end else if (clk_en) begin
            area5_wait_ff            <= nxt_area5_wait;
            area4_wait_ff            <= nxt_area4_wait;
            area3_wait_ff            <= nxt_area3_wait;
            access_state_ctrl_reg_ff <= nxt_access_state_ctrl_reg;
            prdata_ff                <= nxt_prdata;
            pready_ff                <= nxt_pready;
            pslverr_ff               <= nxt_pslverr;
        end
    end

    // Per-area selection; other areas run without waits here
    always_comb begin
        cfg = '0;
        unique case (acc_req.area)
            AWC_AREA5: cfg = '{access_state_ctrl_reg_ff[AWC_AREA5_THREE_STATE_SEL_BIT], area5_wait_ff};
            AWC_AREA4: cfg = '{access_state_ctrl_reg_ff[AWC_AREA4_THREE_STATE_SEL_BIT], area4_wait_ff};
            AWC_AREA3: cfg = '{access_state_ctrl_reg_ff[AWC_AREA3_THREE_STATE_SEL_BIT], area3_wait_ff};
            AWC_AREA_OTHER: cfg = '{1'b0, 3'h0};
        endcase
        if (!cfg.three_state) begin
            cfg.waits = 3'h0;
        end
    end

    // Launch gate; done and its echo hold off a relaunch while the
    // requester is still dropping valid, at the cost of two idle states
    always_comb begin
        nxt_last_cyc = last_cyc_ff;
        nxt_start    = acc_req.valid && !busy && !start_ff && !done && !acc_done_ff;
        nxt_acc_busy = busy || start_ff;
        if (done) begin
            nxt_last_cyc = {28'h0, len};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff        <= '0;
            start_ff      <= 1'b0;
            last_cyc_ff   <= 32'h0;
            acc_busy_ff   <= 1'b0;
            acc_done_ff   <= 1'b0;
            acc_states_ff <= 4'h0;
        end else if (clk_en) begin
            cfg_ff        <= cfg;
            start_ff      <= nxt_start;
            last_cyc_ff   <= nxt_last_cyc;
            acc_busy_ff   <= nxt_acc_busy;
            acc_done_ff   <= done;
            acc_states_ff <= len;
        end
    end

    awc_cycle u_cycle (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .start     (start_ff),
        .cfg       (cfg_ff),
        .busy_ff   (busy),
        .done_ff   (done),
        .length_ff (len)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);

    // Register map and reserved bits
    reserved_low_a: assert property (pready_ff && $past(paddr) == AWC_OFS_WAIT_A_LOW
        |-> prdata_ff[7] == 1'b0 && prdata_ff[3] == 1'b0)
        else $error("reserved low bit set");
    reserved_high_a: assert property (pready_ff && $past(paddr) == AWC_OFS_WAIT_B_HIGH
        |-> prdata_ff[15] == 1'b0 && prdata_ff[11] == 1'b0)
        else $error("reserved high bit set");
    area5_write_a: assert property (wr_en && paddr == AWC_OFS_WAIT_A_LOW
        |=> area5_wait_ff == $past(pwdata[6:4]))
        else $error("area5 field not written");
    area4_write_a: assert property (wr_en && paddr == AWC_OFS_WAIT_A_LOW
        |=> area4_wait_ff == $past(pwdata[2:0]))
        else $error("area4 field not written");
    area3_write_a: assert property (wr_en && paddr == AWC_OFS_WAIT_B_HIGH
        |=> area3_wait_ff == $past(pwdata[14:12]))
        else $error("area3 field not written");
    ast_write_a: assert property (wr_en && paddr == AWC_OFS_ACCESS_CTRL
        |=> access_state_ctrl_reg_ff == $past(pwdata[7:0]))
        else $error("access-state register not written");

    // Area selection
    area5_sel_a: assert property (acc_req.area == AWC_AREA5 && access_state_ctrl_reg_ff[AWC_AREA5_THREE_STATE_SEL_BIT]
        |-> cfg.waits == area5_wait_ff)
        else $error("area5 waits not applied");
    area4_sel_a: assert property (acc_req.area == AWC_AREA4 && access_state_ctrl_reg_ff[AWC_AREA4_THREE_STATE_SEL_BIT]
        |-> cfg.waits == area4_wait_ff)
        else $error("area4 waits not applied");
    area3_sel_a: assert property (acc_req.area == AWC_AREA3 && access_state_ctrl_reg_ff[AWC_AREA3_THREE_STATE_SEL_BIT]
        |-> cfg.waits == area3_wait_ff)
        else $error("area3 waits not applied");
    area5_off_a: assert property (acc_req.area == AWC_AREA5 && !access_state_ctrl_reg_ff[AWC_AREA5_THREE_STATE_SEL_BIT]
        |-> cfg.waits == 3'h0 && !cfg.three_state)
        else $error("area5 waits applied in two-state");
    area4_off_a: assert property (acc_req.area == AWC_AREA4 && !access_state_ctrl_reg_ff[AWC_AREA4_THREE_STATE_SEL_BIT]
        |-> cfg.waits == 3'h0 && !cfg.three_state)
        else $error("area4 waits applied in two-state");
    area3_off_a: assert property (acc_req.area == AWC_AREA3 && !access_state_ctrl_reg_ff[AWC_AREA3_THREE_STATE_SEL_BIT]
        |-> cfg.waits == 3'h0 && !cfg.three_state)
        else $error("area3 waits applied in two-state");

    // Cycle timing
    two_state_a: assert property (start_ff && !cfg_ff.three_state
        |=> busy ##1 busy ##1 done)
        else $error("two-state cycle length wrong");
    wait_len_a: assert property (start_ff && cfg_ff.three_state
        |=> len == AWC_THREE_STATE + {1'b0, cfg_ff.waits})
        else $error("wait length wrong");
    status_len_a: assert property (done
        |=> last_cyc_ff == {28'h0, $past(len)})
        else $error("status length not captured");
    no_restart_a: assert property (acc_done_ff
        |-> !start_ff && !acc_busy_ff)
        else $error("access relaunched on held request");

    cov_three_state_c: cover property (start_ff && cfg_ff.three_state && cfg_ff.waits == 3'h7);
    cov_two_state_c: cover property (start_ff && !cfg_ff.three_state);
    cov_read_c: cover property (pready_ff && !pslverr_ff && $past(!pwrite));
    cov_err_c: cover property (pready_ff && pslverr_ff);
    cov_ast_write_c: cover property (wr_en && paddr == AWC_OFS_ACCESS_CTRL);

endmodule : awc_top

`default_nettype wire

// ==== core/awc_pkg.sv ====
// Purpose: Shared constants and types for the area wait-state control block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Register offsets are byte addresses

package awc_pkg;

    // Register map
    localparam logic [7:0] AWC_OFS_WAIT_A_LOW  = 8'h00;
    localparam logic [7:0] AWC_OFS_WAIT_B_HIGH = 8'h04;
    localparam logic [7:0] AWC_OFS_ACCESS_CTRL = 8'h08;
    localparam logic [7:0] AWC_OFS_CYCLE_CTRL  = 8'h0c;
    localparam logic [7:0] AWC_OFS_STATUS      = 8'h10;

    // Field positions
    localparam int AWC_AREA5_LSB = 4;
    localparam int AWC_AREA4_LSB = 0;
    localparam int AWC_AREA3_LSB = 12;
    localparam int AWC_AREA5_THREE_STATE_SEL_BIT  = 5;
    localparam int AWC_AREA4_THREE_STATE_SEL_BIT  = 4;
    localparam int AWC_AREA3_THREE_STATE_SEL_BIT  = 3;

    // Reset values
    localparam logic [2:0] AWC_WAIT_RST = 3'h7;
    localparam logic [7:0] AWC_AST_RST  = 8'hff;

    // Base cycle lengths in system-clock states
    localparam logic [3:0] AWC_TWO_STATE   = 4'h2;
    localparam logic [3:0] AWC_THREE_STATE = 4'h3;

    typedef enum logic [1:0] {
        AWC_AREA3,
        AWC_AREA4,
        AWC_AREA5,
        AWC_AREA_OTHER
    } awc_area_t;

    typedef struct packed {
        logic       valid;
        awc_area_t  area;
    } awc_req_t;

    typedef struct packed {
        logic       three_state;
        logic [2:0] waits;
    } awc_cfg_t;

endpackage : awc_pkg

// ==== core/awc_cycle.sv ====
// Purpose: Times one external bus cycle from its state count and waits
// Assumes: Request comes from logic on pclk
// Notes:   Busy while counting; done pulses in the cycle after the last state

`timescale 1ns/100ps
`default_nettype none

module awc_cycle
    import awc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    input  wire logic       start,
    input  wire awc_cfg_t   cfg,
    output var  logic       busy_ff,
    output var  logic       done_ff,
    output var  logic [3:0] length_ff
);

    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic       nxt_busy;
    logic       nxt_done;
    logic [3:0] nxt_length;
    logic [3:0] total;

    always_comb begin
        // 2-state without waits, 3-state plus one state per wait
        total = cfg.three_state ? AWC_THREE_STATE + {1'b0, cfg.waits} : AWC_TWO_STATE;
        nxt_cnt    = cnt_ff;
        nxt_busy   = busy_ff;
        nxt_done   = 1'b0;
        nxt_length = length_ff;
        if (busy_ff) begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end
        end else if (start) begin
            nxt_cnt    = total;
            nxt_length = total;
            nxt_busy   = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff    <= 4'h0;
            busy_ff   <= 1'b0;
            done_ff   <= 1'b0;
            length_ff <= 4'h0;
        end else if (clk_en) begin
            cnt_ff    <= nxt_cnt;
            busy_ff   <= nxt_busy;
            done_ff   <= nxt_done;
            length_ff <= nxt_length;
        end
    end

endmodule : awc_cycle

`default_nettype wire

// ==== test/awc_top_tb_top.sv ====
// Purpose: Self-checking bench for the area wait-state control block
// Assumes: One-wait APB slave; clk_en dropped only by the freeze test
// Notes:   Latency of an access is checked absolutely and against a reference: zero waits in t_areas, unfrozen in t_freeze

`timescale 1ns/100ps
`default_nettype none

module awc_top_tb_top
    import awc_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    awc_req_t    acc_req;
    logic        acc_busy_ff;
    logic        acc_done_ff;
    logic [3:0]  acc_states_ff;
    int          errors;
    int          check_count;

    awc_top awc_top_i (
        .pclk          (pclk),
        .presetn       (presetn),
        .clk_en        (clk_en),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata_ff     (prdata_ff),
        .pready_ff     (pready_ff),
        .pslverr_ff    (pslverr_ff),
        .acc_req       (acc_req),
        .acc_busy_ff   (acc_busy_ff),
        .acc_done_ff   (acc_done_ff),
        .acc_states_ff (acc_states_ff)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // Starts one edge in so a release and a new setup never share a step
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready_ff !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata_ff;
        err  = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic ex_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, ex);
        check({31'h0, e}, {31'h0, ex_err});
    endtask : rd

    // Holds the request until done, as the access handshake asks
    task automatic acc(input awc_area_t ar, input logic [3:0] ex, input int stall, output int k);
        int b;
        k = 0;
        b = 0;
        @(posedge pclk);
        acc_req <= '{valid: 1'b1, area: ar};
        @(posedge pclk);
        while (acc_done_ff !== 1'b1) begin
            @(posedge pclk);
            k++;
            if (acc_busy_ff === 1'b1) begin
                b++;
            end
        end
        acc_req <= '{valid: 1'b0, area: ar};
        check({28'h0, acc_states_ff}, {28'h0, ex});
        check(32'(k), 32'(ex) + 32'(stall) + 32'h3);
        // Busy spans the load edge through the last state
        check(32'(b), 32'(ex) + 32'(stall) + 32'h1);
        check({31'h0, acc_busy_ff}, 32'h0);
        rd(AWC_OFS_STATUS, {28'h0, ex}, 1'b0);
    endtask : acc

    task automatic t_regs();
        rd(AWC_OFS_WAIT_A_LOW, 32'h77, 1'b0);
        rd(AWC_OFS_WAIT_B_HIGH, 32'h7000, 1'b0);
        rd(AWC_OFS_ACCESS_CTRL, 32'hff, 1'b0);
        wr(AWC_OFS_WAIT_A_LOW, 32'hffffffff);
        wr(AWC_OFS_WAIT_B_HIGH, 32'hffffffff);
        rd(AWC_OFS_WAIT_A_LOW, 32'h77, 1'b0);
        rd(AWC_OFS_WAIT_B_HIGH, 32'h7000, 1'b0);
        wr(AWC_OFS_WAIT_A_LOW, 32'h35);
        wr(AWC_OFS_WAIT_B_HIGH, 32'h6000);
        rd(AWC_OFS_WAIT_A_LOW, 32'h35, 1'b0);
        rd(AWC_OFS_WAIT_B_HIGH, 32'h6000, 1'b0);
        rd(AWC_OFS_CYCLE_CTRL, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        $display("register test done");
    endtask : t_regs

    // Neighbour fields hold two waits so a crossed field shows up
    task automatic t_areas();
        logic [2:0] w;
        int         k;
        int         k0;
        for (int a = 0; a < 3; a++) begin
            for (int s = 0; s < 2; s++) begin
                for (int i = 0; i < 2; i++) begin
                    w = (i == 1) ? 3'h7 : 3'h0;
                    wr(AWC_OFS_WAIT_A_LOW, {25'h0, (a == 2) ? w : 3'h2, 1'b0, (a == 1) ? w : 3'h2});
                    wr(AWC_OFS_WAIT_B_HIGH, {17'h0, (a == 0) ? w : 3'h2, 12'h0});
                    wr(AWC_OFS_ACCESS_CTRL, (s == 1) ? 32'hff : 32'hff ^ (32'h1 << (AWC_AREA3_THREE_STATE_SEL_BIT + a)));
                    acc(awc_area_t'(a), (s == 1) ? 4'h3 + {1'b0, w} : 4'h2, 0, k);
                    if (i == 0) begin
                        k0 = k;
                    end else begin
                        check(32'(k - k0), (s == 1) ? 32'h7 : 32'h0);
                    end
                end
            end
        end
        acc(AWC_AREA_OTHER, 4'h2, 0, k);
        $display("area timing test done");
    endtask : t_areas

    // Four frozen edges mid-access must stretch it by exactly four
    task automatic t_freeze();
        int k0;
        int k;
        wr(AWC_OFS_ACCESS_CTRL, 32'hff);
        wr(AWC_OFS_WAIT_B_HIGH, 32'h1000);
        acc(AWC_AREA3, 4'h4, 0, k0);
        fork
            acc(AWC_AREA3, 4'h4, 4, k);
            begin
                repeat (3) @(posedge pclk);
                clk_en <= 1'b0;
                repeat (4) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        check(32'(k - k0), 32'h4);
        $display("freeze test done");
    endtask : t_freeze

    // Mid-run reset must restore the access-state reset value and clear status
    task automatic t_reset();
        wr(AWC_OFS_ACCESS_CTRL, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(AWC_OFS_ACCESS_CTRL, 32'hff, 1'b0);
        rd(AWC_OFS_WAIT_A_LOW, 32'h77, 1'b0);
        rd(AWC_OFS_STATUS, 32'h0, 1'b0);
        $display("reset test done");
    endtask : t_reset

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        test_done();
    end

    initial begin
        errors      = 0;
        check_count = 0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        acc_req     = '0;
        clk_en      = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_areas();
        t_freeze();
        t_reset();
        test_done();
    end
endmodule : awc_top_tb_top

`default_nettype wire
